/* File: tnhr_regs.sv */
// Purpose: Host register bank of a token-passing node controller:
//          buffer pointer, select index and configuration.
// Assumes: External synchronous buffer RAM answers one cycle
//          after ram_re; protocol engine shares mclk.
// Notes:   Reserved bits read as zero.
`timescale 1ns/10ps
`include "tnhr_defines.svh"

module tnhr_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic      [10:0] ram_addr,
  output logic      [7:0]  ram_wdata,
  output logic             ram_we,
  output logic             ram_re,
  input  wire logic [7:0]  ram_rdata,
  input  wire logic        next_id_valid,
  input  wire logic [7:0]  next_id_in,
  input  wire logic [2:0]  line_req,
  output logic             soft_reset,
  output logic             chaining_enable,
  output logic             transmit_allow,
  output logic             backplane_mode,
  output logic             line_driver_enable_n,
  output logic             line_pulse_a_n,
  output logic             line_pulse_b_n
);
  import tnhr_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------

  // Address match, used by every strobe decode
  function automatic logic hit(input logic [2:0] a,
                               input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // State and strobes
  // ----------------------------------------
  tnhr_state_t s_q;
  tnhr_state_t s_d;
  logic [10:0] ptr;
  logic [2:0]  idx;
  logic        wr_ptru;
  logic        wr_ptrl;
  logic        wr_suba;
  logic        wr_cfg;
  logic        wr_indx;
  logic        acc_wr;
  logic        acc_rd;
  logic        step;
  logic [2:0]  line_n;

  // Full select index; low bits are config storage
  assign idx = {s_q.idx_msb, s_q.cfg[1:0]};

  // Register write strobes
  assign wr_ptru = wr && hit(addr, `TNHR_OFS_PTRU);
  assign wr_ptrl = wr && hit(addr, `TNHR_OFS_PTRL);
  assign wr_suba = wr && hit(addr, `TNHR_OFS_SUBA);
  assign wr_cfg  = wr && hit(addr, `TNHR_OFS_CFG);
  assign wr_indx = wr && hit(addr, `TNHR_OFS_INDX);

  // Buffer accesses honour the prepared direction
  assign acc_wr = wr && hit(addr, `TNHR_OFS_DATA) && !s_q.dir;
  assign acc_rd = rd && hit(addr, `TNHR_OFS_DATA) && s_q.dir;

  // Step only after an honoured access
  assign step = (acc_wr || acc_rd) && s_q.step_en;

  // ----------------------------------------
  // Buffer pointer
  // ----------------------------------------

  // Pointer counter with carry across the byte split
  tnhr_ptr_ctr u_ptr (
    .mclk    (mclk),
    .rst     (rst),
    .load_hi (wr_ptru),
    .load_lo (wr_ptrl),
    .wdata   (wdata),
    .step    (step),
    .ptr     (ptr)
  );

  // RAM port; address is the pointer flop
  assign ram_addr  = ptr;
  assign ram_wdata = wdata;
  assign ram_we    = acc_wr;
  assign ram_re    = acc_rd;

  // ----------------------------------------
  // Register update
  // ----------------------------------------

  // Next state of every register
  always_comb begin
    s_d        = s_q;
    s_d.rd_ram = 1'b0;
    s_d.rdata  = `TNHR_RST_BYTE;

    // Upper pointer control bits; reserved bits dropped
    if (wr_ptru) begin
      s_d.dir     = wdata[`TNHR_PU_DIR];
      s_d.step_en = wdata[`TNHR_PU_STEP];
    end

    // Select index; low bits land in config storage
    if (wr_suba) begin
      s_d.idx_msb = wdata[2];
      s_d.cfg[1:0] = wdata[1:0];
    end

    // Config write also drops the index top bit
    if (wr_cfg) begin
      s_d.cfg     = wdata;
      s_d.idx_msb = 1'b0;
    end

    // Window at 07; reserved codes ignore writes
    if (wr_indx) begin
      case (idx)
        `TNHR_IX_TENT: s_d.tent = wdata;
        `TNHR_IX_NODE: s_d.node = wdata;
        `TNHR_IX_SET1: s_d.set1 = wdata;
        `TNHR_IX_SET2: s_d.set2 = wdata;
        default: s_d.tent = s_q.tent;
      endcase
    end

    // Next ID follows the engine outside soft reset
    if (next_id_valid) begin
      s_d.next_id = next_id_in;
    end

    // Soft reset phase follows config bit 7
    case (s_q.swr)
      TNHR_SW_RUN: begin
        if (s_d.cfg[`TNHR_CF_SRST]) begin
          s_d.swr = TNHR_SW_HELD;
        end
      end
      TNHR_SW_HELD: begin
        // Only a host write of 0 lets the node go
        if (!s_d.cfg[`TNHR_CF_SRST]) begin
          s_d.swr = TNHR_SW_RUN;
        end
      end
      default: s_d.swr = TNHR_SW_RUN;
    endcase

    // Held reset clears next ID; other registers keep
    if (s_q.swr == TNHR_SW_HELD) begin
      s_d.next_id = `TNHR_RST_BYTE;
    end

    // Read data, valid the cycle after the strobe
    if (rd) begin
      case (addr)
        `TNHR_OFS_DATA: s_d.rd_ram = acc_rd;
        `TNHR_OFS_PTRU: s_d.rdata = {s_q.dir, s_q.step_en, 3'h0, ptr[10:8]};
        `TNHR_OFS_PTRL: s_d.rdata = ptr[7:0];
        `TNHR_OFS_SUBA: s_d.rdata = {5'h00, idx};
        `TNHR_OFS_CFG:  s_d.rdata = s_q.cfg;
        `TNHR_OFS_INDX: begin
          case (idx)
            `TNHR_IX_TENT: s_d.rdata = s_q.tent;
            `TNHR_IX_NODE: s_d.rdata = s_q.node;
            `TNHR_IX_SET1: s_d.rdata = s_q.set1;
            `TNHR_IX_NEXT: s_d.rdata = s_q.next_id;
            `TNHR_IX_SET2: s_d.rdata = s_q.set2;
            default:       s_d.rdata = `TNHR_RST_BYTE;
          endcase
        end
        default: s_d.rdata = `TNHR_RST_BYTE;
      endcase
    end
  end

  // Single state register; all cleared by hard reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{swr: TNHR_SW_RUN, dir: 1'b0, step_en: 1'b0,
               idx_msb: 1'b0, cfg: `TNHR_RST_BYTE,
               tent: `TNHR_RST_BYTE, node: `TNHR_RST_BYTE,
               set1: `TNHR_RST_BYTE, set2: `TNHR_RST_BYTE,
               next_id: `TNHR_RST_BYTE, rd_ram: 1'b0,
               rdata: `TNHR_RST_BYTE};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Buffer data bypasses s_q.rdata; both come from flops
  assign rdata = s_q.rd_ram ? ram_rdata : s_q.rdata;

  // Engine controls; chaining off means legacy flow
  assign soft_reset      = (s_q.swr == TNHR_SW_HELD);
  assign chaining_enable = s_q.cfg[`TNHR_CF_CHAIN];
  assign transmit_allow  = s_q.cfg[`TNHR_CF_TRANSMIT_ALLOW];
  assign backplane_mode  = s_q.cfg[`TNHR_CF_BPLANE];

  // Line outputs stay idle until transmit is allowed, except the pulse lines in backplane mode
  tnhr_tx_gate u_gate (
    .mclk      (mclk),
    .rst       (rst),
    .allow     (transmit_allow),
    .backplane (backplane_mode),
    .req       (line_req),
    .out_n     (line_n)
  );

  assign line_driver_enable_n = line_n[0];
  assign line_pulse_a_n       = line_n[1];
  assign line_pulse_b_n       = line_n[2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Pointer after a stepping access
  logic [10:0] ptr_plus;
  assign ptr_plus = ptr + `TNHR_PTR_ONE;

  chk_dir_blocks_write: assert property (
    wr && hit(addr, `TNHR_OFS_DATA) && s_q.dir |-> !ram_we)
    else $error("buffer write taken in read direction");

  chk_dir_blocks_read: assert property (
    rd && hit(addr, `TNHR_OFS_DATA) && !s_q.dir |=> rdata == 8'h00)
    else $error("buffer read answered in write direction");

  chk_step_after_access: assert property (
    (ram_we || ram_re) && s_q.step_en |=> ptr == $past(ptr_plus))
    else $error("pointer did not step by one");

  chk_hold_no_step: assert property (
    (ram_we || ram_re) && !s_q.step_en |=> $stable(ptr))
    else $error("pointer moved without stepping");

  chk_upper_ptr_load: assert property (
    wr_ptru |=> ptr[10:8] == $past(wdata[2:0]) && $stable(ptr[7:0]))
    else $error("upper pointer load wrong");

  chk_lower_ptr_load: assert property (
    wr_ptrl |=> ptr[7:0] == $past(wdata) && $stable(ptr[10:8]))
    else $error("lower pointer load wrong");

  chk_shared_select: assert property (
    wr_suba |=> s_q.cfg[1:0] == $past(wdata[1:0]))
    else $error("select bits not shared with config");

  chk_cfg_clears_msb: assert property (
    wr_cfg |=> !s_q.idx_msb)
    else $error("config write kept index top bit");

  chk_srst_next_id: assert property (
    soft_reset ##1 soft_reset |-> s_q.next_id == 8'h00)
    else $error("next ID survives soft reset");

  chk_srst_keeps_cfg: assert property (
    soft_reset && !wr_cfg && !wr_suba |=> $stable(s_q.cfg))
    else $error("soft reset disturbed config");

  chk_tx_quiet: assert property (
    !transmit_allow ##1 !transmit_allow |-> line_driver_enable_n)
    else $error("driver enabled while transmit disallowed");

  // Wrap, read-only window, reserved bits, soft reset and config fields
  chk_ptr_wrap: assert property (
    (ram_we || ram_re) && s_q.step_en && (&ptr) |=> ptr == `TNHR_RST_PTR)
    else $error("pointer did not wrap to zero");

  chk_next_id_ro: assert property (
    wr_indx && idx == `TNHR_IX_NEXT && !next_id_valid && !soft_reset |=> $stable(s_q.next_id))
    else $error("window write reached next ID");

  chk_index_rsvd_zero: assert property (
    rd && hit(addr, `TNHR_OFS_SUBA) |=> rdata[7:3] == 5'h00)
    else $error("index reserved bits not zero");

  chk_upper_rsvd_zero: assert property (
    rd && hit(addr, `TNHR_OFS_PTRU) |=> rdata[5:3] == 3'h0)
    else $error("pointer reserved bits not zero");

  chk_srst_enter: assert property (
    wr_cfg && wdata[`TNHR_CF_SRST] |=> soft_reset)
    else $error("soft reset not entered");

  chk_srst_hold: assert property (
    soft_reset && !wr_cfg |=> soft_reset)
    else $error("soft reset left without host write");

  chk_chain_bit: assert property (
    wr_cfg |=> chaining_enable == $past(wdata[`TNHR_CF_CHAIN]))
    else $error("chaining enable not taken");

  chk_tx_allow_bit: assert property (
    wr_cfg |=> transmit_allow == $past(wdata[`TNHR_CF_TRANSMIT_ALLOW]))
    else $error("transmit allow not taken");

  chk_pulse_quiet: assert property (
    !transmit_allow && !backplane_mode |=> line_pulse_a_n && line_pulse_b_n)
    else $error("pulse line active while transmit disallowed");

  // Main scenarios
  cov_stream_read: cover property (
    ram_re && s_q.step_en ##1 ram_re);
  cov_soft_reset: cover property (
    !soft_reset ##1 soft_reset [*3] ##1 !soft_reset);
  cov_window_next: cover property (
    rd && hit(addr, `TNHR_OFS_INDX) && idx == `TNHR_IX_NEXT);
  cov_line_drive: cover property (!line_driver_enable_n);

endmodule

/* File: tnhr_defines.svh */
// Purpose: Offsets, field positions and reset values of the
//          token node host register bank.
// Assumes: Byte-wide register port with a 3-bit address.
// Notes:   Definitions only; included by bare name.
`ifndef TNHR_DEFINES_SVH
`define TNHR_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TNHR_OFS_DATA  3'h1
`define TNHR_OFS_PTRU  3'h2
`define TNHR_OFS_PTRL  3'h3
`define TNHR_OFS_SUBA  3'h5
`define TNHR_OFS_CFG   3'h6
`define TNHR_OFS_INDX  3'h7

// ----------------------------------------
// Upper pointer fields
// ----------------------------------------
`define TNHR_PU_DIR    7
`define TNHR_PU_STEP   6

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define TNHR_CF_SRST   7
`define TNHR_CF_CHAIN  6
`define TNHR_CF_TRANSMIT_ALLOW   5
`define TNHR_CF_BPLANE 2

// ----------------------------------------
// Select index codes for the window at 07
// ----------------------------------------
`define TNHR_IX_TENT   3'h0
`define TNHR_IX_NODE   3'h1
`define TNHR_IX_SET1   3'h2
`define TNHR_IX_NEXT   3'h3
`define TNHR_IX_SET2   3'h4

// ----------------------------------------
// Reset values and pointer step
// ----------------------------------------
`define TNHR_RST_BYTE  8'h00
`define TNHR_RST_PTR   11'h000
`define TNHR_PTR_ONE   11'h001

`endif

/* File: tnhr_pkg.sv */
// Purpose: Types shared by the token node host register bank.
// Assumes: Constants live in tnhr_defines.svh.
// Notes:   Each module except the RAM model and bench keeps its whole state in one struct.
package tnhr_pkg;

  // Software reset phase
  typedef enum logic [0:0] {
    TNHR_SW_RUN  = 1'b0,
    TNHR_SW_HELD = 1'b1
  } tnhr_swr_t;

  // Main register state
  typedef struct packed {
    tnhr_swr_t  swr;
    logic       dir;
    logic       step_en;
    logic       idx_msb;
    logic [7:0] cfg;
    logic [7:0] tent;
    logic [7:0] node;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] next_id;
    logic       rd_ram;
    logic [7:0] rdata;
  } tnhr_state_t;

  // Pointer counter state
  typedef struct packed {
    logic [10:0] ptr;
  } tnhr_ptr_state_t;

  // Line output state, active low
  typedef struct packed {
    logic [2:0] out_n;
  } tnhr_gate_state_t;

endpackage

/* File: tnhr_ptr_ctr.sv */
// Purpose: 11-bit buffer pointer with byte loads and stepping.
// Assumes: Loads and step never coincide (one strobe a cycle).
// Notes:   Wraps from the top buffer address to zero.
`timescale 1ns/10ps
`include "tnhr_defines.svh"

module tnhr_ptr_ctr (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load_hi,
  input  wire logic        load_lo,
  input  wire logic [7:0]  wdata,
  input  wire logic        step,
  output logic      [10:0] ptr
);
  import tnhr_pkg::*;

  tnhr_ptr_state_t s_q;
  tnhr_ptr_state_t s_d;

  // Next pointer value
  always_comb begin
    s_d = s_q;
    if (load_hi) begin
      s_d.ptr[10:8] = wdata[2:0];
    end else if (load_lo) begin
      s_d.ptr[7:0] = wdata;
    end else if (step) begin
      // One counter, so the low byte carries upward
      s_d.ptr = s_q.ptr + `TNHR_PTR_ONE;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{ptr: `TNHR_RST_PTR};
    end else begin
      s_q <= s_d;
    end
  end

  assign ptr = s_q.ptr;
endmodule

/* File: tnhr_tx_gate.sv */
// Purpose: Gates the active-low line outputs by transmit allow; pulse lines pass ungated in backplane mode.
// Assumes: Requests come from the protocol engine, same clock.
// Notes:   Bit 0 driver enable, bits 2:1 the two pulse lines.
`timescale 1ns/10ps

module tnhr_tx_gate (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       allow,
  input  wire logic       backplane,
  input  wire logic [2:0] req,
  output logic      [2:0] out_n
);
  import tnhr_pkg::*;

  tnhr_gate_state_t s_q;
  tnhr_gate_state_t s_d;
  logic [2:0]       keep;

  // Pulses are forced quiet only outside backplane mode
  assign keep[0] = 1'b1;
  assign keep[1] = !backplane;
  assign keep[2] = !backplane;

  // Same gate on each line
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 3; i++) begin
      s_d.out_n[i] = !(req[i] && (allow || !keep[i]));
    end
  end

  // Outputs idle high from reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{out_n: 3'h7};
    end else begin
      s_q <= s_d;
    end
  end

  assign out_n = s_q.out_n;
endmodule

/* File: tnhr_ram_model.sv */
// Purpose: Synchronous buffer RAM seen from the register bank.
// Assumes: One read or write pulse a cycle, same clock.
// Notes:   Outside a read answer the data lines toggle.
`timescale 1ns/10ps

module tnhr_ram_model (
  input  wire logic        mclk,
  input  wire logic [10:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  input  wire logic        ram_we,
  input  wire logic        ram_re,
  output logic      [7:0]  ram_rdata
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] mem [0:2047];

  initial begin
    ram_rdata = 8'h00;
  end

  // Write on the pulse, answer a read next cycle only
  always @(posedge mclk) begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;  // write access
    if (ram_re)
      ram_rdata <= mem[ram_addr];  // read access
    else
      ram_rdata <= ~ram_rdata;     // Stale data must never pass as valid
  end
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench of the token node host registers.
// Assumes: RAM model on the buffer port, bench as host and engine.
// Notes:   Read results are queued and checked by a watcher.
`timescale 1ns/10ps
`include "tnhr_defines.svh"

module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        mclk, rst, wr, rd, nid_v, rd_p;
  logic [2:0]  addr, line_req;
  logic [7:0]  wdata, rdata, ram_wdata, ram_rdata, nid, e;
  logic [10:0] ram_addr, ptr_m;
  logic        ram_we, ram_re, s_rst, chain, allow, bplane;
  logic        drv_n, pa_n, pb_n, dir_m, step_m;
  logic [7:0]  mem_m [0:2047];
  logic [7:0]  win [0:7];
  logic [7:0]  exp_q [$];
  logic [7:0]  cf [0:3];
  logic [31:0] r;
  int          err_total, samples_checked, seed, cyc;

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  tnhr_regs u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_re(ram_re), .ram_rdata(ram_rdata), .next_id_valid(nid_v), .next_id_in(nid),
    .line_req(line_req), .soft_reset(s_rst), .chaining_enable(chain),
    .transmit_allow(allow), .backplane_mode(bplane), .line_driver_enable_n(drv_n),
    .line_pulse_a_n(pa_n), .line_pulse_b_n(pb_n));

  tnhr_ram_model u_ram (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chk_v(string n, logic [10:0] x, logic [10:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk_b(string n, logic x, logic g);
    chk_v(n, {10'h000, x}, {10'h000, g});
  endtask

  // One strobe cycle; a read queues its expected answer
  task automatic xfer(logic w, logic [2:0] a, logic [7:0] d, logic [7:0] x);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w)
      exp_q.push_back(x);
    @(posedge mclk);
  endtask

  task automatic idle;
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge mclk);
  endtask

  // Buffer access; refused when direction disagrees
  task automatic data(logic w, logic [7:0] d);
    logic ok;
    ok = w ^ dir_m;
    if (w && ok)
      mem_m[ptr_m] = d;
    addr <= `TNHR_OFS_DATA;
    wdata <= d;
    wr <= w;
    rd <= !w;
    exp_q.push_back((!w && ok) ? mem_m[ptr_m] : 8'h00);
    if (w)
      void'(exp_q.pop_back());
    @(negedge mclk);
    chk_v("ram_addr", ptr_m, ram_addr);  // pointer drives address
    chk_b("ram_we", w & ok, ram_we);     // direction gates write
    chk_b("ram_re", !w & ok, ram_re);    // direction gates read
    if (w && ok)
      chk_v("ram_wdata", {3'h0, d}, {3'h0, ram_wdata});
    if (ok && step_m)
      ptr_m = ptr_m + 11'h001;           // one 11-bit counter
    @(posedge mclk);
  endtask

  task automatic setp(logic dr, logic st, logic [10:0] p);
    dir_m = dr;
    step_m = st;
    ptr_m = p;
    xfer(1'h1, `TNHR_OFS_PTRU, {dr, st, 3'h0, p[10:8]}, 8'h00);
    xfer(1'h1, `TNHR_OFS_PTRL, p[7:0], 8'h00);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Read watcher and timeout
  // ----------------------------------------
  always @(posedge mclk) begin
    rd_p <= rd;
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      $display("Error timeout expected done seen hang");
      finish_test;
    end
  end

  // Read data stands one cycle only, so look at it then
  always @(negedge mclk) begin
    if (rd_p === 1'h1) begin
      e = exp_q.pop_front();
      chk_v("rdata", {3'h0, e}, {3'h0, rdata});
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 72;
    rst = 1'h1;
    {wr, rd, nid_v, addr, wdata, line_req, nid} = 0;
    cf = '{8'h00, 8'h20, 8'h44, 8'h64};
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    for (int i = 2; i < 8; i++)
      xfer(1'h0, i[2:0], 8'h00, 8'h00);  // all zero after reset
    idle;
    // Look mid-cycle, never in the edge's own time step
    @(negedge mclk);
    chk_b("transmit_allow", 1'h0, allow);  // cleared at reset
    chk_b("line_driver_enable_n", 1'h1, drv_n);  // quiet at reset
    @(posedge mclk);
    $display("test reset done");
    setp(1'h0, 1'h1, 11'h7FE);  // write direction, stepping
    xfer(1'h0, `TNHR_OFS_PTRU, 8'h00, 8'h47);  // fields read back
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      data(1'h1, r[7:0]);  // writes across the wrap
    end
    data(1'h0, 8'h00);  // read refused in write direction
    setp(1'h1, 1'h1, 11'h7FE);  // read direction, stepping
    repeat (3) data(1'h0, 8'h00);  // reads across the wrap
    setp(1'h1, 1'h0, 11'h7FF);  // stepping off
    repeat (2) data(1'h0, 8'h00);  // pointer held
    data(1'h1, 8'h5A);             // write refused in read direction
    idle;
    $display("test pointer done");
    xfer(1'h1, `TNHR_OFS_CFG, 8'h03, 8'h00);
    xfer(1'h0, `TNHR_OFS_SUBA, 8'h00, 8'h03);  // shared low bits
    xfer(1'h1, `TNHR_OFS_SUBA, 8'h04, 8'h00);
    xfer(1'h0, `TNHR_OFS_SUBA, 8'h00, 8'h04);  // top bit stored
    xfer(1'h0, `TNHR_OFS_CFG, 8'h00, 8'h00);   // index write reaches config
    xfer(1'h1, `TNHR_OFS_CFG, 8'h02, 8'h00);
    xfer(1'h0, `TNHR_OFS_SUBA, 8'h00, 8'h02);  // config write clears top bit
    r = $random(seed);
    nid <= r[7:0];
    nid_v <= 1'h1;
    idle;  // engine loads next ID
    nid_v <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      win[i] = (i == 3) ? nid : ((i < 5) ? r[15:8] + i[7:0] : 8'h00);
      xfer(1'h1, `TNHR_OFS_SUBA, {5'h00, i[2:0]}, 8'h00);
      xfer(1'h1, `TNHR_OFS_INDX, r[15:8] + i[7:0], 8'h00);
      xfer(1'h0, `TNHR_OFS_INDX, 8'h00, win[i]);  // window per code
    end
    idle;
    $display("test index done");
    xfer(1'h1, `TNHR_OFS_CFG, 8'hA3, 8'h00);  // enter soft reset
    idle;
    @(negedge mclk);
    chk_b("soft_reset", 1'h1, s_rst);       // held while bit set
    @(posedge mclk);
    xfer(1'h0, `TNHR_OFS_INDX, 8'h00, 8'h00);  // next ID cleared
    xfer(1'h0, `TNHR_OFS_CFG, 8'h00, 8'hA3);   // config kept
    xfer(1'h0, `TNHR_OFS_PTRL, 8'h00, 8'hFF);  // pointer kept
    xfer(1'h1, `TNHR_OFS_SUBA, 8'h01, 8'h00);
    xfer(1'h0, `TNHR_OFS_INDX, 8'h00, win[1]);  // node ID kept
    xfer(1'h1, `TNHR_OFS_CFG, 8'h23, 8'h00);    // host releases
    idle;
    @(negedge mclk);
    chk_b("soft_reset", 1'h0, s_rst);  // released
    @(posedge mclk);
    $display("test soft reset done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, `TNHR_OFS_CFG, cf[i], 8'h00);
      line_req <= 3'h7;
      idle;
      // Line outputs launch at that edge; sample them settled
      @(negedge mclk);
      chk_b("chaining_enable", cf[i][6], chain);
      chk_b("transmit_allow", cf[i][5], allow);
      chk_b("backplane_mode", cf[i][2], bplane);
      chk_b("line_driver_enable_n", !cf[i][5], drv_n);
      chk_b("line_pulse_a_n", !(cf[i][5] | cf[i][2]), pa_n);
      chk_b("line_pulse_b_n", !(cf[i][5] | cf[i][2]), pb_n);
      @(posedge mclk);
      line_req <= 3'h0;
    end
    $display("test transmit done");
    finish_test;
  end
endmodule
